//--- core/eip_edge.sv
// Edge detector for one external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module eip_edge
  import eip_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic pin, // Pin level, synchronous to hclk
  input wire logic [NIB_W-1:0] ctrl, // Pin control nibble
  output logic event_o // One-cycle detection pulse
);

  eip_edge_st_t st_r;
  eip_edge_st_t st_nxt;
  logic gate;
  logic act;

  // Detection works on the gated level, polarity-adjusted for single edge only, so a control write
  // itself can produce an edge; software masks the interrupt around it
  always_comb begin
    gate = ctrl[CTRL_EN_BIT] & pin;
    act = ctrl[CTRL_EN_BIT] & (ctrl[CTRL_POL_BIT] ? pin : ~pin);
    st_nxt.prev_act = act;
    st_nxt.prev_gate = gate;
    if (ctrl[CTRL_BOTH_BIT]) begin
      event_o = gate ^ st_r.prev_gate;
    end else begin
      event_o = act & ~st_r.prev_act;
    end
  end

  // History of both views of the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : eip_edge
`default_nettype wire

//--- core/eip_top.sv
// External interrupt pins, skip-test logic and power-down entry, AHB-Lite slave
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eip_top
  import eip_pkg::*;
(
  input wire logic hclk, // System clock, 25 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write not read
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic hreadyout, // Slave ready out
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic first_ext_irq_pin, // First external interrupt pin
  input wire logic second_ext_irq_pin, // Second external interrupt pin
  input wire logic [1:0] irq_accept, // Core accepted request, one pulse per pin
  output logic [1:0] irq_req, // Interrupt request to the core
  output logic powerdown_o, // Device in power-down stop state
  output logic ram_backup_o // Device in RAM back-up state
);

  eip_state_t st_r;
  eip_state_t st_nxt;
  logic [1:0] pin_evt;
  logic addr_ok;
  logic cmd_wr;
  eip_cmd_t cmd;

  // True when the address lands on a word we decode
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_CTRL0) || (a == ADDR_CTRL1) || (a == ADDR_IEN) ||
                (a == ADDR_CMD) || (a == ADDR_STAT);
  endfunction : is_mapped

  // Read view of a state; used so reads see writes from the same cycle
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input eip_state_t s);
    logic [31:0] w;
    w = '0;
    if (a == ADDR_CTRL0) begin
      w[NIB_W-1:0] = s.ctrl0;
    end else if (a == ADDR_CTRL1) begin
      w[NIB_W-1:0] = s.ctrl1;
    end else if (a == ADDR_IEN) begin
      w[NIB_W-1:0] = s.ien;
    end else if (a == ADDR_STAT) begin
      w[STAT_FLAG_LSB +: 2] = s.flag;
      w[STAT_SKIP_BIT] = s.skip;
      w[STAT_PD_LSB +: 2] = s.pd;
    end
    read_word = w;
  endfunction : read_word

  // Skip-test: valid only while the pin's interrupt is disabled
  function automatic logic skip_valid(input logic [NIB_W-1:0] ien, input int idx);
    skip_valid = ~ien[idx];
  endfunction : skip_valid

  // One detector per pin
  eip_edge u_edge0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(first_ext_irq_pin),
    .ctrl(st_r.ctrl0),
    .event_o(pin_evt[0])
  );

  eip_edge u_edge1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(second_ext_irq_pin),
    .ctrl(st_r.ctrl1),
    .event_o(pin_evt[1])
  );

  // Next-state logic: bus data phase, commands, flags and power-down
  always_comb begin
    st_nxt = st_r;
    addr_ok = 1'b0;
    cmd_wr = st_r.wr_pend && (st_r.wr_addr == ADDR_CMD);
    cmd = eip_cmd_t'(hwdata[CMD_W-1:0]);

    // Write data phase; zero wait states so hwdata stands now
    if (st_r.wr_pend) begin
      if (st_r.wr_addr == ADDR_CTRL0) begin
        st_nxt.ctrl0 = hwdata[NIB_W-1:0];
      end
      if (st_r.wr_addr == ADDR_CTRL1) begin
        st_nxt.ctrl1 = hwdata[NIB_W-1:0];
      end
      if (st_r.wr_addr == ADDR_IEN) begin
        st_nxt.ien = hwdata[NIB_W-1:0];
      end
    end

    // Skip-test commands report and clear the flag in one step
    if (cmd_wr && cmd == CMD_SKIP0) begin
      if (skip_valid(st_r.ien, IEN_PIN0_BIT)) begin
        st_nxt.skip = st_r.flag[0];
        st_nxt.flag[0] = 1'b0;
      end else begin
        st_nxt.skip = 1'b0;
      end
    end
    if (cmd_wr && cmd == CMD_SKIP1) begin
      if (skip_valid(st_r.ien, IEN_PIN1_BIT)) begin
        st_nxt.skip = st_r.flag[1];
        st_nxt.flag[1] = 1'b0;
      end else begin
        st_nxt.skip = 1'b0;
      end
    end

    // Accept clears; a new edge in the same cycle wins so it is not lost
    st_nxt.flag = (st_nxt.flag & ~irq_accept) | pin_evt;

    // Any other bus write breaks the enable-then-power-down pairing
    unique case (st_r.pd)
      PD_RUN: begin
        if (cmd_wr && cmd == CMD_PD_EN) begin
          st_nxt.pd = PD_ARMED;
        end
      end
      PD_ARMED: begin
        if (st_r.wr_pend) begin
          if (cmd_wr && cmd == CMD_PD) begin
            st_nxt.pd = PD_STOP;
          end else if (cmd_wr && cmd == CMD_BACKUP) begin
            st_nxt.pd = PD_BACKUP;
          end else if (cmd_wr && cmd == CMD_PD_EN) begin
            st_nxt.pd = PD_ARMED;
          end else begin
            st_nxt.pd = PD_RUN;
          end
        end
      end
      PD_STOP, PD_BACKUP: begin
        // Wake on any detected pin edge; the bus itself stays alive
        if (|pin_evt) begin
          st_nxt.pd = PD_RUN;
        end
      end
    endcase

    // Power state decoded ahead of the flops so the outputs carry no logic
    st_nxt.pd_stop = (st_nxt.pd == PD_STOP);
    st_nxt.pd_backup = (st_nxt.pd == PD_BACKUP);

    // Request follows flag and enable, registered for a clean output
    st_nxt.irq[0] = st_nxt.flag[0] & st_nxt.ien[IEN_PIN0_BIT];
    st_nxt.irq[1] = st_nxt.flag[1] & st_nxt.ien[IEN_PIN1_BIT];

    // Address phase: capture writes, answer reads from next state
    st_nxt.wr_pend = 1'b0;
    st_nxt.bus.hrdata = '0;
    st_nxt.bus.hreadyout = 1'b1;
    st_nxt.bus.hresp = 1'b0;
    if (hsel && hready && htrans[1]) begin
      addr_ok = is_mapped(haddr[ADDR_W-1:0]) && (haddr[31:ADDR_W] == '0);
      if (hwrite) begin
        st_nxt.wr_pend = 1'b1;
        st_nxt.wr_addr = addr_ok ? haddr[ADDR_W-1:0] : ADDR_STAT;
      end else if (addr_ok) begin
        st_nxt.bus.hrdata = read_word(haddr[ADDR_W-1:0], st_nxt);
      end
    end
  end

  // Single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.ctrl0 <= CTRL_RST;
      st_r.ctrl1 <= CTRL_RST;
      st_r.ien <= IEN_RST;
      st_r.flag <= '0;
      st_r.irq <= '0;
      st_r.skip <= 1'b0;
      st_r.pd <= PD_RUN;
      st_r.pd_stop <= 1'b0;
      st_r.pd_backup <= 1'b0;
      st_r.wr_pend <= 1'b0;
      st_r.wr_addr <= '0;
      st_r.bus.hreadyout <= 1'b1;
      st_r.bus.hresp <= 1'b0;
      st_r.bus.hrdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = st_r.bus.hreadyout;
  assign hresp = st_r.bus.hresp;
  assign hrdata = st_r.bus.hrdata;
  assign irq_req = st_r.irq;
  assign powerdown_o = st_r.pd_stop;
  assign ram_backup_o = st_r.pd_backup;

endmodule : eip_top
`default_nettype wire

//--- inc/eip_pkg.sv
// Package for the external interrupt pin and power-down entry block
// Notes on behaviour
// - Changing polarity of the first pin may set its request flag, per pin level.
// - Changing input enable of the second pin may set its request flag.
// - Changing polarity of the second pin may set its request flag.
// - First skip-test clears first flag; issue it one instruction after the change.
// - Second skip-test clears second flag; issue it one instruction after the change.
// - Skip-test may skip the next instruction when set; software follows it with a no-op.
// - Clearing second pin enable disables that pin's input path.
// - Power-down is entered only when a power-down command directly follows the enable.
// - A power-down command without the enable just before it does nothing.
// - Control bit 3 gates the pin input: 0 off, 1 on.
// - Control bit 2: 0 falling edge or low level, 1 rising edge or high.
// - Control bit 1: 0 single selected edge, 1 both edges.
// - Enable bit 0 disables interrupt and makes skip-test valid; 1 the reverse.
package eip_pkg;

  localparam int NIB_W = 4;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IEN = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h10;

  // Pin control fields
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_BOTH_BIT = 1;

  // Enable register fields
  localparam int IEN_PIN0_BIT = 0;
  localparam int IEN_PIN1_BIT = 1;

  // Status register fields
  localparam int STAT_FLAG_LSB = 0;
  localparam int STAT_SKIP_BIT = 2;
  localparam int STAT_PD_LSB = 3;

  localparam logic [NIB_W-1:0] CTRL_RST = 4'h0;
  localparam logic [NIB_W-1:0] IEN_RST = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int CMD_W = 3;

  // Command codes written to the command register
  typedef enum logic [CMD_W-1:0] {
    CMD_NOP = 3'b000,
    CMD_SKIP0 = 3'b001,
    CMD_SKIP1 = 3'b010,
    CMD_PD_EN = 3'b011,
    CMD_PD = 3'b100,
    CMD_BACKUP = 3'b101
  } eip_cmd_t;

  // Power-down sequencer
  typedef enum logic [1:0] {
    PD_RUN = 2'b00,
    PD_ARMED = 2'b01,
    PD_STOP = 2'b10,
    PD_BACKUP = 2'b11
  } eip_pd_t;

  // Bus-facing outputs travel together
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } eip_ahb_out_t;

  typedef struct packed {
    logic [NIB_W-1:0] ctrl0;
    logic [NIB_W-1:0] ctrl1;
    logic [NIB_W-1:0] ien;
    logic [1:0] flag;
    logic [1:0] irq;
    logic skip;
    eip_pd_t pd;
    logic pd_stop;
    logic pd_backup;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    eip_ahb_out_t bus;
  } eip_state_t;

  typedef struct packed {
    logic prev_act;
    logic prev_gate;
  } eip_edge_st_t;

endpackage : eip_pkg

//--- tb/eip_pins.sv
// Driver model of the two external interrupt pins
`timescale 1ns/1ps
`default_nettype none
module eip_pins (
  input wire logic hclk, // Clock
  input wire logic [1:0] lvl, // Wanted levels
  output logic [1:0] pins // Pin levels
);
  // Changes land just after an edge, so the block never sees a half-step
  always_ff @(posedge hclk) begin
    pins <= lvl;
  end
endmodule : eip_pins
`default_nettype wire

//--- tb/eip_top_asserts.sv
// Timing checker for the pin interrupt and power-down block
`timescale 1ns/1ps
`default_nettype none
module eip_top_asserts
  import eip_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Wdata
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata, // Rdata
  input wire logic first_ext_irq_pin, // Pin 0
  input wire logic second_ext_irq_pin, // Pin 1
  input wire logic [1:0] irq_accept, // Accept
  input wire logic [1:0] irq_req, // Request
  input wire logic powerdown_o, // Stop
  input wire logic ram_backup_o // Backup
);
  logic wr_r, rd_r, arm_r, chg, cmd_w;
  logic [7:0] a_r;
  logic [1:0] pin_r, pins;
  logic [3:0] act_r;
  logic go_stop, go_backup, rel1;
  // Named causes, so the past-value checks look at plain signals
  assign go_stop = cmd_w & arm_r & (hwdata[2:0] == CMD_PD);
  assign go_backup = cmd_w & arm_r & (hwdata[2:0] == CMD_BACKUP);
  assign rel1 = irq_accept[1] | wr_r;
  // Activity history lets the checks tell a spontaneous change from a caused one
  assign pins = {second_ext_irq_pin, first_ext_irq_pin};
  assign cmd_w = wr_r & (a_r == ADDR_CMD);
  assign chg = wr_r | (pins != pin_r);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_r, rd_r, arm_r, a_r, pin_r, act_r} <= '0;
    end else begin
      wr_r <= hsel & hready & htrans[1] & hwrite;
      rd_r <= hsel & hready & htrans[1] & ~hwrite;
      a_r <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
      if (wr_r) begin
        arm_r <= cmd_w & (hwdata[2:0] == CMD_PD_EN); // Any other write disarms
      end
      pin_r <= pins;
      act_r <= {act_r[2:0], chg};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_zero_wait: assert property (hreadyout)
    else $error("wait state seen");
  chk_rdata_idle: assert property (!rd_r |-> hrdata == 32'h0)
    else $error("stray read data");
  chk_okay_resp: assert property (!hresp)
    else $error("error response seen");
  chk_pd_entry: assert property (
    $rose(powerdown_o) |-> $past(go_stop))
    else $error("bad stop entry");
  chk_backup_entry: assert property (
    $rose(ram_backup_o) |-> $past(go_backup))
    else $error("bad backup entry");
  chk_wake_cause: assert property ($fell(powerdown_o) |-> act_r != 4'h0)
    else $error("wake without pin");
  chk_accept_clr: assert property (irq_accept[0] && act_r == 4'h0 && !chg |=> !irq_req[0])
    else $error("accept kept request");
  chk_req_holds: assert property ($fell(irq_req[1]) |-> $past(rel1))
    else $error("request dropped");
  chk_req_cause: assert property ($rose(irq_req[0]) |-> act_r != 4'h0)
    else $error("request from nothing");
endmodule : eip_top_asserts
bind eip_top eip_top_asserts eip_top_asserts_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .first_ext_irq_pin(first_ext_irq_pin), .second_ext_irq_pin(second_ext_irq_pin),
  .irq_accept(irq_accept), .irq_req(irq_req), .powerdown_o(powerdown_o),
  .ram_backup_o(ram_backup_o));
`default_nettype wire

//--- tb/ext_irq_pin_and_powerdown_entry_bench.sv
// Self-checking bench with a reference model of flags and power state
`timescale 1ns/1ps
`default_nettype none
module ext_irq_pin_and_powerdown_entry_bench;
  import eip_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ms = 1'b0;
  logic hreadyout, hresp, powerdown_o, ram_backup_o;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r, rnd = 32'h06D3;
  logic [1:0] htrans = '0, lvl = '0, irq_accept = '0, pins, irq_req;
  logic [1:0] mf = '0, pa = '0, pg = '0;
  logic [3:0] mc [2] = '{4'h0, 4'h0};
  logic [3:0] mi = '0;
  int mpd = 0, err_total = 0, n_tests = 0;
  int seq [12] = '{4, 3, 4, 3, 8, 3, 0, 4, 3, 3, 5, 8};
  // Clock stands for a resonator, so the power-down commands may be used
  always #20 hclk = ~hclk;
  eip_pins eip_pins_inst (.hclk(hclk), .lvl(lvl), .pins(pins));
  eip_top eip_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .first_ext_irq_pin(pins[0]),
    .second_ext_irq_pin(pins[1]), .irq_accept(irq_accept), .irq_req(irq_req),
    .powerdown_o(powerdown_o), .ram_backup_o(ram_backup_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Single transfer; address held until ready, then data held until ready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, HTRANS_NONSEQ, w, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  // Single edge sees a rise of the polarity-gated level, both-edge any change
  task automatic m_eval();
    logic a, g;
    for (int i = 0; i < 2; i++) begin
      a = mc[i][3] & (mc[i][2] ? lvl[i] : ~lvl[i]);
      g = mc[i][3] & lvl[i];
      if (mc[i][1] ? g != pg[i] : a & ~pa[i]) begin
        mf[i] = 1'b1;
        mpd = (mpd > 1) ? 0 : mpd;
      end
      {pa[i], pg[i]} = {a, g};
    end
  endtask : m_eval
  task automatic mw(input logic [7:0] a, input logic [3:0] d);
    int arm;
    bus(1'b1, {24'h0, a}, {28'h0, d});
    arm = (mpd == 1);
    mpd = arm ? 0 : mpd;
    case (a)
      ADDR_CTRL0: mc[0] = d;
      ADDR_CTRL1: mc[1] = d;
      ADDR_IEN: mi = d;
      ADDR_CMD: begin
        if (d == CMD_SKIP0 || d == CMD_SKIP1) begin
          ms = mf[d-1] & ~mi[d-1];
          mf[d-1] = mf[d-1] & mi[d-1];
        end
        mpd = (d == CMD_PD_EN && mpd < 2) ? 1 : mpd;
        mpd = (arm && d == CMD_PD) ? 2 : mpd;
        mpd = (arm && d == CMD_BACKUP) ? 3 : mpd;
      end
      default: ;
    endcase
    m_eval();
    repeat (2) @(posedge hclk);
  endtask : mw
  task automatic pin(input int i);
    lvl[i] <= ~lvl[i];
    repeat (3) @(posedge hclk);
    m_eval();
  endtask : pin
  task automatic check_all();
    bus(1'b0, 32'(ADDR_STAT), 32'h0);
    chk(r, {27'h0, 2'(mpd), ms, mf});
    chk(32'(irq_req), 32'(mf & mi[1:0]));
    chk(32'(powerdown_o), 32'(mpd == 2));
    chk(32'(ram_backup_o), 32'(mpd == 3));
  endtask : check_all
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    check_all();
    // Unmapped places and the command word read as zero
    mw(8'h14, 4'hF);
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, k == 0 ? 32'h14 : k == 1 ? 32'h100 : 32'(ADDR_CMD), 32'h0);
      chk(r, 32'h0);
    end
    // Lone command, proper pair, stop state woken, broken pair, repeated enable and back-up pair, back-up state woken
    mw(ADDR_IEN, 4'h0);
    mw(ADDR_CTRL0, 4'h8);
    mw(ADDR_CTRL1, 4'h0);
    foreach (seq[k]) begin
      if (seq[k] == 8) begin
        pin(0);
        pin(0);
      end else begin
        mw(ADDR_CMD, 4'(seq[k]));
      end
      check_all();
    end
    repeat (300) begin
      rnd = lfsr(rnd);
      case (rnd[2:0])
        3'h0, 3'h1: pin(int'(rnd[3]));
        3'h2: begin
          mw(ADDR_IEN, mi & ~(4'h1 << rnd[3]));
          mw(rnd[3] ? ADDR_CTRL1 : ADDR_CTRL0, rnd[7:4]);
        end
        3'h3: mw(ADDR_IEN, rnd[7:4]);
        3'h4: mw(ADDR_CMD, {2'h0, rnd[5:4]} % 4'h3);
        3'h5: begin
          irq_accept <= rnd[5:4];
          @(posedge hclk);
          irq_accept <= 2'h0;
          mf = mf & ~rnd[5:4];
        end
        default: begin
          bus(1'b0, rnd[3] ? 32'(ADDR_CTRL1) : 32'(ADDR_CTRL0), 32'h0);
          chk(r, {28'h0, mc[rnd[3]]});
        end
      endcase
      check_all();
    end
    close_out();
  end
  // Cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    close_out();
  end
endmodule : ext_irq_pin_and_powerdown_entry_bench
`default_nettype wire
